// ==== src/mia_pkg.sv ====
// package: constants, types and helpers of the interrupt acknowledge unit
package mia_pkg;

    localparam int N_SRC   = 6;
    localparam int SRC_W   = 3;
    localparam int AXI_AW  = 8;
    localparam int STACK_DEPTH = 16;

    // status word, mask and flag reset values
    localparam logic [7:0]       STATUS_WORD_RESET     = 8'h02;
    localparam int               GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam logic [N_SRC-1:0] MASK_RESET            = 6'h3f;
    localparam logic [N_SRC-1:0] FLAGS_RESET           = 6'h00;

    // register byte offsets
    localparam logic [AXI_AW-1:0] OFF_STATUS_WORD       = 8'h00;
    localparam logic [AXI_AW-1:0] OFF_STATUS_SET        = 8'h04;
    localparam logic [AXI_AW-1:0] OFF_STATUS_CLR        = 8'h08;
    localparam logic [AXI_AW-1:0] OFF_REQ_FLAGS         = 8'h0c;
    localparam logic [AXI_AW-1:0] OFF_MASK_FLAGS        = 8'h10;
    localparam logic [AXI_AW-1:0] OFF_SLOW_OSC_MODE_REG = 8'h14;
    localparam logic [AXI_AW-1:0] OFF_CONFIG            = 8'h18;
    localparam logic [AXI_AW-1:0] OFF_STATE             = 8'h1c;

    localparam int SLOW_OSC_STOP_BIT  = 0;
    localparam int CFG_SW_STOP_OK_BIT = 0;
    localparam int CFG_WDT_SLOW_BIT   = 1;

    // vector table base, two bytes per source
    localparam logic [15:0] VEC_BASE = 16'h0006;

    // latency in cpu clocks
    localparam int ACK_MAX_CYC = 19;
    localparam int LAT_W       = $clog2(ACK_MAX_CYC + 1);

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        SEQ_IDLE      = 4'h0,
        SEQ_PUSH_STAT = 4'h1,
        SEQ_PUSH_PCH  = 4'h3,
        SEQ_PUSH_PCL  = 4'h2,
        SEQ_VECTOR    = 4'h6,
        SEQ_POP_PCL   = 4'h8,
        SEQ_POP_PCH   = 4'h9,
        SEQ_POP_STAT  = 4'hb,
        SEQ_RETURN    = 4'ha
    } mia_seq_t;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } mia_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mia_axi_rsp_t;

    typedef struct packed {
        logic        instr_done;
        logic        flag_access;
        logic        enable_irq_instr;
        logic        disable_irq_instr;
        logic        irq_return_instr;
        logic        halt_instr;
        logic        stop_instr;
        logic [15:0] pc;
    } mia_core_req_t;

    typedef struct packed {
        logic        irq_take;
        logic        cpu_hold;
        logic        cpu_clk_en;
        logic        pc_load;
        logic [15:0] pc_value;
    } mia_core_rsp_t;

    function automatic logic [15:0] vector_addr(input logic [SRC_W-1:0] idx);
        vector_addr = VEC_BASE + {12'h000, idx, 1'b0};
    endfunction : vector_addr

endpackage : mia_pkg

// ==== src/mia_prio_pick.sv ====
// fixed priority picker, index 0 highest
module mia_prio_pick #(
    parameter int N  = 6,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]  req_i,
    output logic               any_o,
    output logic [IW-1:0]      idx_o
);

    always_comb begin
        any_o = 1'b0;
        idx_o = '0;
        // lowest set index wins
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                idx_o = IW'(i);
            end
        end
    end

endmodule : mia_prio_pick

// ==== src/mia_stack_mem.sv ====
// byte stack memory with registered read data
module mia_stack_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clk_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [W-1:0]  wr_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [W-1:0]  rd_data_o
);

    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule : mia_stack_mem

// ==== src/mia_ack_unit.sv ====
// maskable interrupt acknowledge unit: flags, masks, status word, stacking sequencer, standby
//
// Contract
// - acknowledge pushes the status word and clears the global enable
// - reset sets the status word to 02h
// - acceptable with flag set, mask clear; vectored only with enable
// - request to service start lies between 9 and 19 cpu clocks
// - worst latency comes when a bit test branch instruction starts
// - simultaneous requests: the highest priority one is taken first
// - a refused request stays pending and is taken once allowed
// - push status word then pc, clear enable, load vector, branch
// - a return instruction ends servicing
// - flag set before last clock: acknowledge after current instruction
// - flag set in last clock: acknowledge after the following instruction
// - flag or mask access defers acknowledge past the next instruction
// - no nested request during servicing unless software enables again
// - nesting is not limited by priority; masks must block it
// - status word byte and bit access; enable and disable instructions
// - halt gates the cpu clock while the oscillator keeps running
// - slow osc stop bit acts in stop only if option allows
// - watchdog on the slow oscillator stops in stop mode
// - six sources ranked fixed, index 0 highest to index 5 lowest
// - flag set on request, cleared on acknowledge or reset
// - any unmasked set flag ends standby at once, even while entering
module mia_ack_unit (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire mia_pkg::mia_axi_req_t        axi_i,
    output mia_pkg::mia_axi_rsp_t             axi_o,
    input  wire logic [mia_pkg::N_SRC-1:0]    irq_src_i,
    input  wire mia_pkg::mia_core_req_t       core_i,
    output mia_pkg::mia_core_rsp_t            core_o,
    output logic                              slow_osc_run_o,
    output logic                              wdt_run_o
);

    localparam int SP_W = $clog2(mia_pkg::STACK_DEPTH);
    localparam int IEB  = mia_pkg::GLOBAL_IRQ_ENABLE_BIT;

    typedef struct packed {
        logic [7:0]                    processor_status_word;
        logic [mia_pkg::N_SRC-1:0]     irq_request_flags;
        logic [mia_pkg::N_SRC-1:0]     irq_mask_flags;
        logic                          slow_osc_stop_bit;
        logic [1:0]                    cfg;
        logic                          hold;
        logic                          axi_touch;
        logic                          halted;
        logic                          stopped;
        mia_pkg::mia_seq_t             seq;
        logic [SP_W-1:0]               sp;
        logic [mia_pkg::SRC_W-1:0]     src;
        logic [15:0]                   pc_tmp;
        logic [mia_pkg::LAT_W-1:0]     wait_cnt;
        logic [mia_pkg::LAT_W-1:0]     last_lat;
        mia_pkg::mia_core_rsp_t        core;
        logic                          slow_osc_run;
        logic                          wdt_run;
        logic                          aw_got;
        logic                          w_got;
        logic [mia_pkg::AXI_AW-1:0]    awaddr;
        logic [31:0]                   wdata;
        logic                          wstrb0;
        mia_pkg::mia_axi_rsp_t         axi;
    } mia_state_t;

    localparam mia_state_t ST_RST = '{
        processor_status_word: mia_pkg::STATUS_WORD_RESET,
        irq_request_flags:     mia_pkg::FLAGS_RESET,
        irq_mask_flags:        mia_pkg::MASK_RESET,
        seq:                   mia_pkg::SEQ_IDLE,
        core:                  '{cpu_clk_en: 1'b1, default: '0},
        slow_osc_run:          1'b1,
        wdt_run:               1'b1,
        axi:                   '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
        default:               '0
    };

    mia_state_t                     q;
    mia_state_t                     d;

    logic [mia_pkg::N_SRC-1:0]      cand;
    logic                           any_req;
    logic [mia_pkg::SRC_W-1:0]      pick_idx;
    logic                           st_we;
    logic [7:0]                     st_wdata;
    logic [SP_W-1:0]                st_raddr;
    logic [7:0]                     st_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // submodules

    assign cand = q.irq_request_flags & ~q.irq_mask_flags;

    mia_prio_pick #(
        .N  (mia_pkg::N_SRC),
        .IW (mia_pkg::SRC_W)
    ) u_pick (
        .req_i (cand),
        .any_o (any_req),
        .idx_o (pick_idx)
    );

    mia_stack_mem #(
        .W     (8),
        .DEPTH (mia_pkg::STACK_DEPTH)
    ) u_stack (
        .clk_i     (clk_i),
        .wr_en_i   (st_we),
        .wr_addr_i (q.sp),
        .wr_data_i (st_wdata),
        .rd_addr_i (st_raddr),
        .rd_data_o (st_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0]                stat_n;
        logic [mia_pkg::N_SRC-1:0] flags_n;
        logic [mia_pkg::AXI_AW-1:0] wa;
        logic [mia_pkg::AXI_AW-1:0] ra;
        logic                      touch;
        logic                      accept;

        d        = q;
        stat_n   = q.processor_status_word;
        flags_n  = q.irq_request_flags;
        wa       = {q.awaddr[mia_pkg::AXI_AW-1:2], 2'b00};
        ra       = {axi_i.araddr[mia_pkg::AXI_AW-1:2], 2'b00};
        touch    = 1'b0;
        st_we    = 1'b0;
        st_wdata = q.processor_status_word;
        st_raddr = q.sp - 1'b1;

        d.core.irq_take = 1'b0;
        d.core.pc_load  = 1'b0;

        // aw and w taken in either order
        if (axi_i.awvalid && q.axi.awready) begin
            d.aw_got      = 1'b1;
            d.axi.awready = 1'b0;
            d.awaddr      = axi_i.awaddr;
        end
        if (axi_i.wvalid && q.axi.wready) begin
            d.w_got      = 1'b1;
            d.axi.wready = 1'b0;
            d.wdata      = axi_i.wdata;
            d.wstrb0     = axi_i.wstrb[0];
        end

        if (q.aw_got && q.w_got && !q.axi.bvalid) begin
            d.axi.bvalid = 1'b1;
            d.axi.bresp  = mia_pkg::RESP_OKAY;
            unique case (wa)
                mia_pkg::OFF_STATUS_WORD: begin
                    if (q.wstrb0) stat_n = q.wdata[7:0];
                end
                mia_pkg::OFF_STATUS_SET: begin
                    if (q.wstrb0) stat_n = stat_n | q.wdata[7:0];
                end
                mia_pkg::OFF_STATUS_CLR: begin
                    if (q.wstrb0) stat_n = stat_n & ~q.wdata[7:0];
                end
                mia_pkg::OFF_REQ_FLAGS: begin
                    touch = 1'b1;
                    if (q.wstrb0) flags_n = q.wdata[mia_pkg::N_SRC-1:0];
                end
                mia_pkg::OFF_MASK_FLAGS: begin
                    touch = 1'b1;
                    if (q.wstrb0) d.irq_mask_flags = q.wdata[mia_pkg::N_SRC-1:0];
                end
                mia_pkg::OFF_SLOW_OSC_MODE_REG: begin
                    if (q.wstrb0) d.slow_osc_stop_bit = q.wdata[mia_pkg::SLOW_OSC_STOP_BIT];
                end
                mia_pkg::OFF_CONFIG: begin
                    if (q.wstrb0) d.cfg = q.wdata[1:0];
                end
                mia_pkg::OFF_STATE: ;
                default: d.axi.bresp = mia_pkg::RESP_SLVERR;
            endcase
        end
        if (q.axi.bvalid && axi_i.bready) begin
            d.axi.bvalid  = 1'b0;
            d.aw_got      = 1'b0;
            d.w_got       = 1'b0;
            d.axi.awready = 1'b1;
            d.axi.wready  = 1'b1;
        end

        // read answers one cycle later
        if (axi_i.arvalid && q.axi.arready) begin
            d.axi.arready = 1'b0;
            d.axi.rvalid  = 1'b1;
            d.axi.rresp   = mia_pkg::RESP_OKAY;
            d.axi.rdata   = '0;
            unique case (ra)
                mia_pkg::OFF_STATUS_WORD:  d.axi.rdata = 32'(q.processor_status_word);
                mia_pkg::OFF_STATUS_SET:   d.axi.rdata = 32'(q.processor_status_word);
                mia_pkg::OFF_STATUS_CLR:   d.axi.rdata = 32'(q.processor_status_word);
                mia_pkg::OFF_REQ_FLAGS: begin
                    touch       = 1'b1;
                    d.axi.rdata = 32'(q.irq_request_flags);
                end
                mia_pkg::OFF_MASK_FLAGS: begin
                    touch       = 1'b1;
                    d.axi.rdata = 32'(q.irq_mask_flags);
                end
                mia_pkg::OFF_SLOW_OSC_MODE_REG: d.axi.rdata = 32'(q.slow_osc_stop_bit);
                mia_pkg::OFF_CONFIG:            d.axi.rdata = 32'(q.cfg);
                mia_pkg::OFF_STATE: begin
                    d.axi.rdata = 32'({q.last_lat, q.sp, q.seq, q.hold, q.stopped, q.halted});
                end
                default: d.axi.rresp = mia_pkg::RESP_SLVERR;
            endcase
        end
        if (q.axi.rvalid && axi_i.rready) begin
            d.axi.rvalid  = 1'b0;
            d.axi.arready = 1'b1;
        end

        // flag or mask access defers acknowledge
        if (core_i.instr_done) begin
            d.hold      = core_i.flag_access | q.axi_touch | touch;
            d.axi_touch = touch;
        end else if (touch) begin
            d.hold      = 1'b1;
            d.axi_touch = 1'b1;
        end

        // boundary decisions only; a flag set in the last clock
        // lands too late and waits for the next boundary
        accept = (q.seq == mia_pkg::SEQ_IDLE) && core_i.instr_done && any_req
                 && q.processor_status_word[IEB] && !q.hold
                 && !core_i.irq_return_instr;

        // pending latency, kept for software
        if (q.seq == mia_pkg::SEQ_IDLE && any_req && !accept) begin
            if (q.wait_cnt != '1) d.wait_cnt = q.wait_cnt + 1'b1;
        end else begin
            d.wait_cnt = '0;
        end

        if (q.seq == mia_pkg::SEQ_IDLE) begin
            if (core_i.enable_irq_instr) stat_n[IEB] = 1'b1;
            if (core_i.disable_irq_instr) stat_n[IEB] = 1'b0;
        end

        unique case (q.seq)
            mia_pkg::SEQ_IDLE: begin
                if (core_i.irq_return_instr) begin
                    d.seq           = mia_pkg::SEQ_POP_PCL;
                    d.core.cpu_hold = 1'b1;
                end else if (accept) begin
                    // worst case: boundary after a bit test branch
                    d.seq              = mia_pkg::SEQ_PUSH_STAT;
                    d.src              = pick_idx;
                    d.pc_tmp           = core_i.pc;
                    d.last_lat         = q.wait_cnt;
                    d.core.cpu_hold    = 1'b1;
                    d.core.irq_take    = 1'b1;
                    flags_n[pick_idx]  = 1'b0;
                end
            end
            mia_pkg::SEQ_PUSH_STAT: begin
                st_we       = 1'b1;
                st_wdata    = stat_n;
                stat_n[IEB] = 1'b0;
                d.sp        = q.sp + 1'b1;
                d.seq       = mia_pkg::SEQ_PUSH_PCH;
            end
            mia_pkg::SEQ_PUSH_PCH: begin
                st_we    = 1'b1;
                st_wdata = q.pc_tmp[15:8];
                d.sp     = q.sp + 1'b1;
                d.seq    = mia_pkg::SEQ_PUSH_PCL;
            end
            mia_pkg::SEQ_PUSH_PCL: begin
                st_we    = 1'b1;
                st_wdata = q.pc_tmp[7:0];
                d.sp     = q.sp + 1'b1;
                d.seq    = mia_pkg::SEQ_VECTOR;
            end
            mia_pkg::SEQ_VECTOR: begin
                d.core.pc_load  = 1'b1;
                d.core.pc_value = mia_pkg::vector_addr(q.src);
                d.core.cpu_hold = 1'b0;
                d.seq           = mia_pkg::SEQ_IDLE;
            end
            mia_pkg::SEQ_POP_PCL: begin
                d.sp  = q.sp - 1'b1;
                d.seq = mia_pkg::SEQ_POP_PCH;
            end
            mia_pkg::SEQ_POP_PCH: begin
                d.pc_tmp[7:0] = st_rdata;
                d.sp          = q.sp - 1'b1;
                d.seq         = mia_pkg::SEQ_POP_STAT;
            end
            mia_pkg::SEQ_POP_STAT: begin
                d.pc_tmp[15:8] = st_rdata;
                d.sp           = q.sp - 1'b1;
                d.seq          = mia_pkg::SEQ_RETURN;
            end
            mia_pkg::SEQ_RETURN: begin
                stat_n          = st_rdata;
                d.core.pc_load  = 1'b1;
                d.core.pc_value = q.pc_tmp;
                d.core.cpu_hold = 1'b0;
                d.seq           = mia_pkg::SEQ_IDLE;
            end
            default: begin
                d.core.cpu_hold = 1'b0;
                d.seq           = mia_pkg::SEQ_IDLE;
            end
        endcase

        // events or-ed last: set beats clear
        d.irq_request_flags     = flags_n | irq_src_i;
        d.processor_status_word = stat_n;

        // standby; an unmasked flag cancels even entry
        if (core_i.halt_instr) d.halted = 1'b1;
        if (core_i.stop_instr) d.stopped = 1'b1;
        if (any_req) begin
            d.halted  = 1'b0;
            d.stopped = 1'b0;
        end
        // only the cpu clock is gated in halt
        d.core.cpu_clk_en = !(d.halted || d.stopped);
        d.slow_osc_run    = !(d.stopped && q.cfg[mia_pkg::CFG_SW_STOP_OK_BIT]
                              && q.slow_osc_stop_bit);
        d.wdt_run         = !(d.stopped && q.cfg[mia_pkg::CFG_WDT_SLOW_BIT]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign axi_o          = q.axi;
    assign core_o         = q.core;
    assign slow_osc_run_o = q.slow_osc_run;
    assign wdt_run_o      = q.wdt_run;

endmodule : mia_ack_unit

// ==== testbench/mia_chk.sv ====
// checker: port level assertions
module mia_chk (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire mia_pkg::mia_axi_req_t     axi_i,
    input  wire mia_pkg::mia_axi_rsp_t     axi_o,
    input  wire logic [mia_pkg::N_SRC-1:0] irq_src_i,
    input  wire mia_pkg::mia_core_req_t    core_i,
    input  wire mia_pkg::mia_core_rsp_t    core_o,
    input  wire logic                      slow_osc_run_o,
    input  wire logic                      wdt_run_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_take;
        core_o.irq_take |-> core_o.cpu_hold ##1 !core_o.irq_take;
    endproperty
    a_take: assert property (p_take) else $error("take pulse");
    property p_vec;
        core_o.irq_take |-> ##4 core_o.pc_load && !core_o.pc_value[0]
            && core_o.pc_value >= 16'h0006 && core_o.pc_value <= 16'h0010;
    endproperty
    a_vec: assert property (p_vec) else $error("vector load");
    property p_hold;
        $rose(core_o.cpu_hold) |-> core_o.cpu_hold [*4] ##1 !core_o.cpu_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("hold length");
    // accept only at an idle boundary
    property p_cause;
        core_o.irq_take |-> $past(core_i.instr_done) && !$past(core_o.cpu_hold);
    endproperty
    a_cause: assert property (p_cause) else $error("take cause");
    property p_ret;
        core_i.irq_return_instr && !core_o.cpu_hold |=> core_o.cpu_hold ##4 core_o.pc_load;
    endproperty
    a_ret: assert property (p_ret) else $error("return pop");
    property p_osc;
        $fell(slow_osc_run_o) |-> !core_o.cpu_clk_en;
    endproperty
    a_osc: assert property (p_osc) else $error("slow osc stop");
    property p_wdt;
        $fell(wdt_run_o) |-> !core_o.cpu_clk_en;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog stop");
    property p_bhold;
        axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid && $stable(axi_o.bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response held");
    c_take: cover property (core_o.irq_take);
    c_halt: cover property ($fell(core_o.cpu_clk_en));
    c_err: cover property (axi_o.bvalid && axi_o.bresp == mia_pkg::RESP_SLVERR);
endmodule : mia_chk

// ==== testbench/mia_core_model.sv ====
// cpu core model: four clock instructions
module mia_core_model (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire mia_pkg::mia_core_req_t ctl_i,
    input  wire mia_pkg::mia_core_rsp_t rsp_i,
    output mia_pkg::mia_core_req_t      req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  cnt_q;
    logic [15:0] pc_q;
    logic        done;
    // stalls while held or gated
    assign done = cnt_q == 2'h3 && rsp_i.cpu_clk_en && !rsp_i.cpu_hold;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 2'h0;
            pc_q  <= 16'h0100;
        end else if (rsp_i.pc_load) begin
            pc_q <= rsp_i.pc_value;
        end else if (rsp_i.cpu_clk_en && !rsp_i.cpu_hold) begin
            cnt_q <= cnt_q + 2'h1;
            if (done) pc_q <= pc_q + 16'h0001;
        end
    end
    // commands ride the completing clock
    always_comb begin
        req_o            = done ? ctl_i : '0;
        req_o.instr_done = done;
        req_o.pc         = pc_q;
    end
endmodule : mia_core_model

// ==== testbench/test_mia_ack_unit.sv ====
// testbench: acknowledge unit scenarios
module test_mia_ack_unit;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] OP_EN = 7'h10, OP_DIS = 7'h08, OP_RET = 7'h04;
    localparam logic [6:0] OP_HALT = 7'h02, OP_STOP = 7'h01;
    logic                      clk_i   = 1'b0;
    logic                      rst_n_i = 1'b0;
    mia_pkg::mia_axi_req_t     axi     = '0;
    mia_pkg::mia_axi_rsp_t     axi_o;
    logic [mia_pkg::N_SRC-1:0] irq     = '0;
    mia_pkg::mia_core_req_t    ctl     = '0;
    mia_pkg::mia_core_req_t    core_i;
    mia_pkg::mia_core_rsp_t    core_o;
    logic                      slow_run;
    logic                      wdt_run;
    logic [15:0]               done_pc;
    int                        failures = 0;
    int                        checked  = 0;
    always #25 clk_i = ~clk_i;
    mia_ack_unit uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .axi_i(axi), .axi_o(axi_o),
        .irq_src_i(irq), .core_i(core_i), .core_o(core_o), .slow_osc_run_o(slow_run),
        .wdt_run_o(wdt_run));
    mia_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctl_i(ctl), .rsp_i(core_o),
        .req_o(core_i));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk_i);
        axi.awvalid <= 1'b1;
        axi.awaddr  <= a;
        axi.wvalid  <= 1'b1;
        axi.wdata   <= d;
        axi.wstrb   <= 4'hf;
        axi.bready  <= 1'b1;
        while (pa || pw) begin
            @(posedge clk_i);
            if (pa && axi_o.awready === 1'b1) begin
                pa = 1'b0;
                axi.awvalid <= 1'b0;
            end
            if (pw && axi_o.wready === 1'b1) begin
                pw = 1'b0;
                axi.wvalid <= 1'b0;
            end
        end
        do @(posedge clk_i); while (axi_o.bvalid !== 1'b1);
        r = axi_o.bresp;
        axi.bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        axi.arvalid <= 1'b1;
        axi.araddr  <= a;
        axi.rready  <= 1'b1;
        do @(posedge clk_i); while (axi_o.arready !== 1'b1);
        axi.arvalid <= 1'b0;
        do @(posedge clk_i); while (axi_o.rvalid !== 1'b1);
        d = axi_o.rdata;
        r = axi_o.rresp;
        axi.rready <= 1'b0;
    endtask : rd
    // command rides the next instruction completion
    task op(input logic [6:0] b);
        @(posedge clk_i);
        ctl <= mia_pkg::mia_core_req_t'({b, 16'h0000});
        do @(posedge clk_i); while (core_i.instr_done !== 1'b1);
        ctl <= '0;
    endtask : op
    task pulse(input logic [mia_pkg::N_SRC-1:0] s);
        @(posedge clk_i);
        irq <= s;
        @(posedge clk_i);
        irq <= '0;
    endtask : pulse
    // bounded pc load wait; a miss leaves ffff
    task wait_pc(input int lim, output logic [15:0] v);
        v = 16'hffff;
        for (int i = 0; i < lim; i++) begin
            @(posedge clk_i);
            if (core_i.instr_done === 1'b1) done_pc = core_i.pc;
            if (core_o.pc_load === 1'b1) begin
                v = core_o.pc_value;
                break;
            end
        end
    endtask : wait_pc
    task quiet(output int c);
        c = 0;
        repeat (20) begin
            @(posedge clk_i);
            if (core_o.irq_take !== 1'b0) c++;
        end
    endtask : quiet
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rd(8'h00, d, r);
        chk("status", d, 32'h0000_0002);
        rd(8'h10, d, r);
        chk("mask", d, 32'h0000_003f);
        rd(8'h0c, d, r);
        chk("flags", d, 32'h0000_0000);
        wr(8'h20, 32'h0000_00ff, r);
        chk("bad write", r, 2'b10);
        rd(8'h20, d, r);
        chk("bad read", r, 2'b10);
    endtask : t_regs
    task t_ack;
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] v, ret;
        int          n;
        wr(8'h10, 32'h0000_0000, r);
        wr(8'h04, 32'h0000_0080, r);
        repeat (12) @(posedge clk_i);
        pulse(6'h0a);
        wait_pc(20, v);
        chk("vector first", v, 16'h0008);
        ret = done_pc;
        rd(8'h00, d, r);
        chk("status in service", d, 32'h0000_0002);
        rd(8'h0c, d, r);
        chk("flags left", d, 32'h0000_0008);
        quiet(n);
        chk("no nesting", n, 0);
        op(OP_RET);
        wait_pc(10, v);
        chk("return pc", v, ret);
        wait_pc(20, v);
        chk("pending taken", v, 16'h000c);
        op(OP_EN);
        pulse(6'h20);
        wait_pc(20, v);
        chk("low nested", v, 16'h0010);
        op(OP_EN);
        op(OP_DIS);
        rd(8'h00, d, r);
        chk("status disabled", d, 32'h0000_0002);
    endtask : t_ack
    task t_standby;
        logic [1:0] r;
        int         n;
        wr(8'h10, 32'h0000_003f, r);
        pulse(6'h04);
        op(OP_HALT);
        repeat (2) @(posedge clk_i);
        chk("halted", core_o.cpu_clk_en, 1'b0);
        wr(8'h10, 32'h0000_003b, r);
        repeat (2) @(posedge clk_i);
        chk("woken", core_o.cpu_clk_en, 1'b1);
        quiet(n);
        chk("disabled no take", n, 0);
        wr(8'h10, 32'h0000_003f, r);
        wr(8'h18, 32'h0000_0003, r);
        wr(8'h14, 32'h0000_0001, r);
        op(OP_STOP);
        repeat (2) @(posedge clk_i);
        chk("slow osc", slow_run, 1'b0);
        chk("watchdog", wdt_run, 1'b0);
        wr(8'h10, 32'h0000_003b, r);
        repeat (2) @(posedge clk_i);
        chk("stop woken", {slow_run, core_o.cpu_clk_en}, 2'b11);
    endtask : t_standby
    task test_done;
        if (failures == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // run needs under a thousand clocks
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_ack();
        t_standby();
        test_done();
    end
endmodule : test_mia_ack_unit
bind mia_ack_unit mia_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .axi_i(axi_i),
    .axi_o(axi_o), .irq_src_i(irq_src_i), .core_i(core_i), .core_o(core_o),
    .slow_osc_run_o(slow_osc_run_o), .wdt_run_o(wdt_run_o));
